// [hdl/pfm_fault_bank.sv]
// fault status, latch-off restart and response mask registers on axi4-lite
//
// Functional notes
// [RL1] status bit 3 reads self test result: 0 pass, 1 fail; read only.
// [RL2] linear regulator oc/ov/uv flags set on detection; write 0 clears once fault gone.
// [RL3] bit 7 flags monitor dac versus regulation dac compare error above 90%.
// [RL4] bit 6 flags regulation dac versus monitor dac compare error above 90%.
// [RL5] bit 5 sets on serial bus crc failure; writing 0 clears it.
// [RL6] bit 4 re-evaluated against stored checksum about every 5 ms.
// [RL7] bit 3 sets on wrong sequencer output order; writing 0 clears it.
// [RL8] bit 2 sets when watchdog reaches twice the slow window without kick.
// [RL9] bit 1 sets when watchdog reaches the slow window before any kick.
// [RL10] bit 0 sets when a kick arrives before the fast window elapsed.
// [RL11] latch-off bit 4 reads 1 when any low-voltage regulator latched off.
// [RL12] software writes 0 to low-voltage restart bit; device then permits restart.
// [RL13] latch-off bit 0 reads 1 when primary buck latched off on fault.
// [RL14] writing 0 to high-voltage restart bit lets primary buck restart.
// [RL15] mask 0 applies the latch policy response, mask 1 suppresses response.
// [RL16] mask reset: severe uv, severe ov, second oc 0; others 1.
// [RL17] checksum recheck flag clears itself once mismatch cause is removed.
// [RL18] writing 1 leaves a flag unchanged; a present fault sets it again at once.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

module pfm_fault_bank
  import pfm_pkg::*;
#(
  parameter int RECHECK_CYCLES = PFM_RECHECK_CYCLES  // recheck interval in clocks
)
(
  input  wire logic                  mclk,            // system clock, 100 MHz
  input  wire logic                  arst_n,          // async reset, active low
  input  wire logic [PFM_ADDR_W-1:0] s_axi_awaddr,    // write address
  input  wire logic                  s_axi_awvalid,   // write address valid
  output logic                       s_axi_awready,   // write address ready
  input  wire logic [31:0]           s_axi_wdata,     // write data
  input  wire logic [3:0]            s_axi_wstrb,     // write byte strobes
  input  wire logic                  s_axi_wvalid,    // write data valid
  output logic                       s_axi_wready,    // write data ready
  output logic [1:0]                 s_axi_bresp,     // write response
  output logic                       s_axi_bvalid,    // write response valid
  input  wire logic                  s_axi_bready,    // write response ready
  input  wire logic [PFM_ADDR_W-1:0] s_axi_araddr,    // read address
  input  wire logic                  s_axi_arvalid,   // read address valid
  output logic                       s_axi_arready,   // read address ready
  output logic [31:0]                s_axi_rdata,     // read data
  output logic [1:0]                 s_axi_rresp,     // read response
  output logic                       s_axi_rvalid,    // read data valid
  input  wire logic                  s_axi_rready,    // read data ready
  input  wire logic                  selftest_fail,   // self test failed, level
  input  wire logic [2:0]            linear_reg_fault,// oc, ov, uv detector levels
  input  wire logic                  dac_mon_vs_reg,  // monitor vs regulation dac error
  input  wire logic                  dac_reg_vs_mon,  // regulation vs monitor dac error
  input  wire logic                  bus_crc_error,   // bus crc failure pulse
  input  wire logic                  config_mismatch, // config checksum mismatch level
  input  wire logic                  seq_order_error, // sequencer order error pulse
  input  wire logic                  wdog_double,     // watchdog double timeout pulse
  input  wire logic                  wdog_late,       // watchdog late kick pulse
  input  wire logic                  wdog_early,      // watchdog early kick pulse
  input  wire logic                  lv_latchoff,     // a low-voltage regulator latched off
  input  wire logic                  hv_latchoff,     // primary buck latched off
  input  wire logic [6:0]            primary_fault,   // primary buck fault events
  output logic                       lv_restart,      // low-voltage restart permit pulse
  output logic                       hv_restart,      // primary buck restart permit pulse
  output logic [6:0]                 primary_respond, // faults that get a response
  output logic [1:0]                 fault_latch_policy // response selection
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  sync_st;
    logic [1:0]  sync_cm;
    logic [2:0]  sync_lr1;
    logic [2:0]  sync_lr2;
    logic [1:0]  sync_lv;
    logic [1:0]  sync_hv;
    logic [2:0]  ldo_flags;
    logic [7:0]  safety;
    logic        lv_flag;
    logic        hv_flag;
    logic [7:0]  resp_mask;
    logic [1:0]  policy;
    logic [31:0] recheck_cnt;
    logic        aw_held;
    logic        w_held;
    logic [PFM_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        lv_restart;
    logic        hv_restart;
    logic [6:0]  respond;
  } pfm_state_type;

  pfm_state_type cur;
  pfm_state_type next_cur;

  localparam pfm_state_type PFM_STATE_RESET = '{
    resp_mask: PFM_RESP_MASK_RESET,
    policy:    PFM_POLICY_RESET,
    default:   '0
  };

  logic       do_write;
  logic       wr_lane0;
  logic [7:0] wr_byte;
  logic [7:0] ldo_read;
  logic [7:0] latch_read;

  assign do_write   = cur.aw_held && cur.w_held && !cur.bvalid;
  assign wr_lane0   = cur.wstrb[0];
  assign wr_byte    = cur.wdata[7:0];
  assign ldo_read   = {4'h0, cur.sync_st[1], cur.ldo_flags};                    // RL1
  assign latch_read = {3'h0, cur.lv_flag, 3'h0, cur.hv_flag};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_cur = cur;
    next_cur.sync_st  = {cur.sync_st[0], selftest_fail};
    next_cur.sync_cm  = {cur.sync_cm[0], config_mismatch};
    next_cur.sync_lr1 = linear_reg_fault;
    next_cur.sync_lr2 = cur.sync_lr1;
    next_cur.sync_lv  = {cur.sync_lv[0], lv_latchoff};
    next_cur.sync_hv  = {cur.sync_hv[0], hv_latchoff};
    next_cur.lv_restart = 1'b0;
    next_cur.hv_restart = 1'b0;

    // write channel capture, either order
    if (s_axi_awvalid && !cur.aw_held)
    begin
      next_cur.aw_held = 1'b1;
      next_cur.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !cur.w_held)
    begin
      next_cur.w_held = 1'b1;
      next_cur.wdata  = s_axi_wdata;
      next_cur.wstrb  = s_axi_wstrb;
    end

    // clears first so that a set in the same cycle wins
    if (do_write)
    begin
      next_cur.aw_held = 1'b0;
      next_cur.w_held  = 1'b0;
      next_cur.bvalid  = 1'b1;
      next_cur.bresp   = PFM_RESP_OKAY;
      case (cur.awaddr)
        PFM_ADDR_LDO_STATUS:
          if (wr_lane0)
            next_cur.ldo_flags = cur.ldo_flags & wr_byte[2:0];                 // RL2 RL18
        PFM_ADDR_SAFETY_STATUS:
          if (wr_lane0)
            next_cur.safety = cur.safety & (wr_byte | ~PFM_SAFETY_W0C_MASK);   // RL5 RL7 RL18
        PFM_ADDR_LATCHOFF:
          if (wr_lane0)
          begin
            if (!wr_byte[PFM_BIT_LV_LATCH])
            begin
              next_cur.lv_flag    = 1'b0;                                      // RL12
              next_cur.lv_restart = 1'b1;                                      // RL12
            end
            if (!wr_byte[PFM_BIT_HV_LATCH])
            begin
              next_cur.hv_flag    = 1'b0;                                      // RL14
              next_cur.hv_restart = 1'b1;                                      // RL14
            end
          end
        PFM_ADDR_RESP_MASK:
          if (wr_lane0)
            next_cur.resp_mask = wr_byte & PFM_RESP_MASK_BITS;
        PFM_ADDR_POLICY:
          if (wr_lane0)
            next_cur.policy = wr_byte[1:0];
        default:
          next_cur.bresp = PFM_RESP_SLVERR;
      endcase
    end
    if (cur.bvalid && s_axi_bready)
      next_cur.bvalid = 1'b0;

    // read channel
    if (s_axi_arvalid && !cur.rvalid)
    begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp  = PFM_RESP_OKAY;
      case (s_axi_araddr)
        PFM_ADDR_LDO_STATUS:    next_cur.rdata = {24'h0, ldo_read};
        PFM_ADDR_SAFETY_STATUS: next_cur.rdata = {24'h0, cur.safety};
        PFM_ADDR_LATCHOFF:      next_cur.rdata = {24'h0, latch_read};             // RL11 RL13
        PFM_ADDR_RESP_MASK:     next_cur.rdata = {24'h0, cur.resp_mask};
        PFM_ADDR_POLICY:        next_cur.rdata = {30'h0, cur.policy};
        default:
        begin
          next_cur.rdata = 32'h0;
          next_cur.rresp = PFM_RESP_SLVERR;
        end
      endcase
    end
    else if (cur.rvalid && s_axi_rready)
      next_cur.rvalid = 1'b0;

    // sticky sets from the detectors
    next_cur.ldo_flags = next_cur.ldo_flags | cur.sync_lr2;                     // RL2 RL18
    next_cur.safety[7] = next_cur.safety[7] | dac_mon_vs_reg;                   // RL3
    next_cur.safety[6] = next_cur.safety[6] | dac_reg_vs_mon;                   // RL4
    next_cur.safety[5] = next_cur.safety[5] | bus_crc_error;                    // RL5
    next_cur.safety[3] = next_cur.safety[3] | seq_order_error;                  // RL7
    next_cur.safety[2] = next_cur.safety[2] | wdog_double;                      // RL8
    next_cur.safety[1] = next_cur.safety[1] | wdog_late;                        // RL9
    next_cur.safety[0] = next_cur.safety[0] | wdog_early;                       // RL10
    next_cur.lv_flag   = next_cur.lv_flag | cur.sync_lv[1];                     // RL11
    next_cur.hv_flag   = next_cur.hv_flag | cur.sync_hv[1];                     // RL13

    // checksum flag follows the mismatch at each recheck tick
    if (cur.recheck_cnt >= 32'(RECHECK_CYCLES - 1))
    begin
      next_cur.recheck_cnt = 32'h0;
      next_cur.safety[4]   = cur.sync_cm[1];                                    // RL6 RL17
    end
    else
      next_cur.recheck_cnt = cur.recheck_cnt + 32'h1;

    next_cur.respond = primary_fault & ~cur.resp_mask[6:0];                     // RL15
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      cur <= PFM_STATE_RESET;                                                   // RL16
    else
      cur <= next_cur;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready      = !cur.aw_held;
  assign s_axi_wready       = !cur.w_held;
  assign s_axi_bvalid       = cur.bvalid;
  assign s_axi_bresp        = cur.bresp;
  assign s_axi_arready      = !cur.rvalid;
  assign s_axi_rvalid       = cur.rvalid;
  assign s_axi_rdata        = cur.rdata;
  assign s_axi_rresp        = cur.rresp;
  assign lv_restart         = cur.lv_restart;
  assign hv_restart         = cur.hv_restart;
  assign primary_respond    = cur.respond;
  assign fault_latch_policy = cur.policy;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  selftest_read_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL1
    ldo_read[PFM_BIT_SELFTEST] == $past(selftest_fail, 2))
    else $error("self test bit does not follow input");

  ldo_sticky_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL2
    cur.sync_lr2[0] |=> cur.ldo_flags[0])
    else $error("linear regulator flag not set");

  dac_mon_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL3
    dac_mon_vs_reg |=> cur.safety[7])
    else $error("monitor dac flag not set");

  dac_reg_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL4
    dac_reg_vs_mon |=> cur.safety[6])
    else $error("regulation dac flag not set");

  bus_crc_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL5
    bus_crc_error |=> cur.safety[5])
    else $error("bus crc flag not set");

  recheck_hold_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL6
    (cur.recheck_cnt != 32'h0) |-> $stable(cur.safety[4]))
    else $error("recheck flag moved between ticks");

  seq_flag_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL7
    seq_order_error |=> cur.safety[3])
    else $error("sequencer flag not set");

  wdog_double_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL8
    wdog_double |=> cur.safety[2])
    else $error("double timeout flag not set");

  wdog_late_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL9
    wdog_late |=> cur.safety[1])
    else $error("late kick flag not set");

  wdog_early_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL10
    wdog_early |=> cur.safety[0])
    else $error("early kick flag not set");

  lv_latch_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL11
    lv_latchoff ##1 lv_latchoff ##1 lv_latchoff |=> latch_read[PFM_BIT_LV_LATCH])
    else $error("low-voltage latch-off not shown");

  lv_restart_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL12
    lv_restart |-> $past(do_write) && $past(cur.awaddr) == PFM_ADDR_LATCHOFF)
    else $error("low-voltage restart without write");

  hv_latch_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL13
    hv_latchoff ##1 hv_latchoff ##1 hv_latchoff |=> latch_read[PFM_BIT_HV_LATCH])
    else $error("primary latch-off not shown");

  hv_restart_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL14
    hv_restart |-> !$past(wr_byte[PFM_BIT_HV_LATCH]))
    else $error("primary restart without zero write");

  mask_gate_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL15
    primary_respond == ($past(primary_fault) & ~$past(cur.resp_mask[6:0])))
    else $error("mask does not gate response");

  recheck_clear_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL17
    (cur.recheck_cnt == 32'h0) |-> cur.safety[4] == $past(cur.sync_cm[1]))
    else $error("recheck flag not refreshed");

  write_one_a: assert property (@(posedge mclk) disable iff (!arst_n) // RL18
    do_write && cur.awaddr == PFM_ADDR_SAFETY_STATUS && cur.wstrb[0]
      && cur.wdata[5] && cur.safety[5] |=> cur.safety[5])
    else $error("write of one changed a flag");

endmodule

// [hdl/pfm_pkg.sv]
// constants for the fault status and mask register bank
package pfm_pkg;

  // ----------------------------------------------------------------
  // register byte addresses (index times four)
  // ----------------------------------------------------------------
  localparam logic [7:0] PFM_IDX_LDO_STATUS    = 8'h82;
  localparam logic [7:0] PFM_IDX_SAFETY_STATUS = 8'h83;
  localparam logic [7:0] PFM_IDX_LATCHOFF      = 8'h84;
  localparam logic [7:0] PFM_IDX_RESP_MASK     = 8'h85;
  localparam logic [7:0] PFM_IDX_POLICY        = 8'h88;
  localparam int         PFM_ADDR_W            = 12;
  localparam logic [11:0] PFM_ADDR_LDO_STATUS    = {2'h0, PFM_IDX_LDO_STATUS, 2'h0};
  localparam logic [11:0] PFM_ADDR_SAFETY_STATUS = {2'h0, PFM_IDX_SAFETY_STATUS, 2'h0};
  localparam logic [11:0] PFM_ADDR_LATCHOFF      = {2'h0, PFM_IDX_LATCHOFF, 2'h0};
  localparam logic [11:0] PFM_ADDR_RESP_MASK     = {2'h0, PFM_IDX_RESP_MASK, 2'h0};
  localparam logic [11:0] PFM_ADDR_POLICY        = {2'h0, PFM_IDX_POLICY, 2'h0};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PFM_BIT_SELFTEST   = 3;
  localparam int PFM_BIT_LV_LATCH   = 4;
  localparam int PFM_BIT_HV_LATCH   = 0;
  localparam logic [7:0] PFM_LDO_W0C_MASK    = 8'h07;
  localparam logic [7:0] PFM_SAFETY_W0C_MASK = 8'hEF;
  localparam logic [7:0] PFM_RESP_MASK_BITS  = 8'h7F;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  // severe uv/ov and second oc unmasked, the rest masked
  localparam logic [7:0] PFM_RESP_MASK_RESET = 8'h17;
  localparam logic [1:0] PFM_POLICY_RESET    = 2'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PFM_CLK_MHZ        = 100;
  localparam int PFM_RECHECK_MS     = 5;
  // ms to clocks: 1000 us per ms, clock rate in cycles per us
  localparam int PFM_RECHECK_CYCLES = PFM_RECHECK_MS * 1000 * PFM_CLK_MHZ;

  // ----------------------------------------------------------------
  // axi responses
  // ----------------------------------------------------------------
  localparam logic [1:0] PFM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PFM_RESP_SLVERR = 2'h2;

endpackage

// [sim/test_pfm_fault_bank.sv]
// self-checking testbench for the fault status and mask register bank
`timescale 1ns/1ps

module test_pfm_fault_bank;
  import pfm_pkg::*;

  // ----------------------------------------------------------------
  // signals and design instance
  // ----------------------------------------------------------------
  localparam int RCYC = 8;

  logic                  mclk;
  logic                  arst_n;
  logic [PFM_ADDR_W-1:0] awaddr;
  logic                  awvalid;
  logic                  awready;
  logic [31:0]           wdata;
  logic [3:0]            wstrb;
  logic                  wvalid;
  logic                  wready;
  logic [1:0]            bresp;
  logic                  bvalid;
  logic                  bready;
  logic [PFM_ADDR_W-1:0] araddr;
  logic                  arvalid;
  logic                  arready;
  logic [31:0]           rdata;
  logic [1:0]            rresp;
  logic                  rvalid;
  logic                  rready;
  logic                  selftest;
  logic [2:0]            lreg;
  logic [7:0]            ev;
  logic                  mism;
  logic                  lv_lo;
  logic                  hv_lo;
  logic [6:0]            pfault;
  logic                  lv_rst;
  logic                  hv_rst;
  logic [6:0]            presp;
  logic [1:0]            policy;
  int                    fail_count;
  int                    checked;
  int                    nlv;
  int                    nhv;
  logic [31:0]           exp;
  int                    evb [7] = '{7, 6, 5, 3, 2, 1, 0};

  pfm_fault_bank #(.RECHECK_CYCLES(RCYC)) pfm_fault_bank_inst (
    .mclk(mclk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .selftest_fail(selftest), .linear_reg_fault(lreg),
    .dac_mon_vs_reg(ev[7]), .dac_reg_vs_mon(ev[6]), .bus_crc_error(ev[5]),
    .config_mismatch(mism), .seq_order_error(ev[3]), .wdog_double(ev[2]),
    .wdog_late(ev[1]), .wdog_early(ev[0]), .lv_latchoff(lv_lo), .hv_latchoff(hv_lo),
    .primary_fault(pfault), .lv_restart(lv_rst), .hv_restart(hv_rst),
    .primary_respond(presp), .fault_latch_policy(policy)
  );

  // ----------------------------------------------------------------
  // compare, bus and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want)
    begin
      fail_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, want);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] want);
    checked++;
    if (got !== want)
    begin
      fail_count++;
      $display("[ERR] %0t response %h expected %h", $time, got, want);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    n = 0;
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 50);
    if (bvalid !== 1'b1)
    begin
      fail_count++;
      $display("[ERR] %0t write got no response", $time);
    end
    chk_resp(bresp, er);
    bready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 50);
    if (rvalid !== 1'b1)
    begin
      fail_count++;
      $display("[ERR] %0t read got no response", $time);
    end
    chk_val(rdata, ed);
    chk_resp(rresp, er);
    rready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic results;
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, restart pulse counters, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    if (lv_rst === 1'b1)
      nlv <= nlv + 1;
    if (hv_rst === 1'b1)
      nhv <= nhv + 1;
  end

  initial
  begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    $display("[ERR] %0t run did not finish in time", $time);
    results();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    {arst_n, awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, selftest, lreg, ev, mism, lv_lo, hv_lo, pfault} = '0;
    {fail_count, checked, nlv, nhv} = '0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    rd(PFM_ADDR_LDO_STATUS, 32'h00, PFM_RESP_OKAY);
    rd(PFM_ADDR_SAFETY_STATUS, 32'h00, PFM_RESP_OKAY);
    rd(PFM_ADDR_LATCHOFF, 32'h00, PFM_RESP_OKAY);
    rd(PFM_ADDR_RESP_MASK, 32'h17, PFM_RESP_OKAY);
    rd(12'h000, 32'h00, PFM_RESP_SLVERR);
    wr(12'h004, 32'hFF, 4'hF, PFM_RESP_SLVERR);
    wr(PFM_ADDR_RESP_MASK, 32'h00, 4'h0, PFM_RESP_OKAY);
    rd(PFM_ADDR_RESP_MASK, 32'h17, PFM_RESP_OKAY);
    // self test result, then linear regulator flags with oc left present
    selftest <= 1'b1;
    lreg     <= 3'h7;
    repeat (5) @(posedge mclk);
    lreg <= 3'h4;
    repeat (5) @(posedge mclk);
    rd(PFM_ADDR_LDO_STATUS, 32'h0F, PFM_RESP_OKAY);
    wr(PFM_ADDR_LDO_STATUS, 32'h07, 4'hF, PFM_RESP_OKAY);
    rd(PFM_ADDR_LDO_STATUS, 32'h0F, PFM_RESP_OKAY);
    wr(PFM_ADDR_LDO_STATUS, 32'h00, 4'hF, PFM_RESP_OKAY);
    rd(PFM_ADDR_LDO_STATUS, 32'h0C, PFM_RESP_OKAY);
    lreg <= 3'h0;
    repeat (5) @(posedge mclk);
    wr(PFM_ADDR_LDO_STATUS, 32'h00, 4'hF, PFM_RESP_OKAY);
    rd(PFM_ADDR_LDO_STATUS, 32'h08, PFM_RESP_OKAY);
    // event flags one at a time
    exp = 32'h0;
    foreach (evb[i])
    begin
      ev[evb[i]] <= 1'b1;
      @(posedge mclk);
      ev[evb[i]] <= 1'b0;
      exp[evb[i]] = 1'b1;
      rd(PFM_ADDR_SAFETY_STATUS, exp, PFM_RESP_OKAY);
    end
    wr(PFM_ADDR_SAFETY_STATUS, 32'hFF, 4'hF, PFM_RESP_OKAY);
    rd(PFM_ADDR_SAFETY_STATUS, 32'hEF, PFM_RESP_OKAY);
    ev[5] <= 1'b1;
    wr(PFM_ADDR_SAFETY_STATUS, 32'h00, 4'hF, PFM_RESP_OKAY);
    ev[5] <= 1'b0;
    rd(PFM_ADDR_SAFETY_STATUS, 32'h20, PFM_RESP_OKAY);
    wr(PFM_ADDR_SAFETY_STATUS, 32'h00, 4'hF, PFM_RESP_OKAY);
    rd(PFM_ADDR_SAFETY_STATUS, 32'h00, PFM_RESP_OKAY);
    // checksum recheck follows the mismatch and ignores writes
    mism <= 1'b1;
    repeat (3 * RCYC + 4) @(posedge mclk);
    rd(PFM_ADDR_SAFETY_STATUS, 32'h10, PFM_RESP_OKAY);
    wr(PFM_ADDR_SAFETY_STATUS, 32'h00, 4'hF, PFM_RESP_OKAY);
    rd(PFM_ADDR_SAFETY_STATUS, 32'h10, PFM_RESP_OKAY);
    mism <= 1'b0;
    repeat (3 * RCYC + 4) @(posedge mclk);
    rd(PFM_ADDR_SAFETY_STATUS, 32'h00, PFM_RESP_OKAY);
    // latch-off flags and restart permits
    lv_lo <= 1'b1;
    hv_lo <= 1'b1;
    repeat (5) @(posedge mclk);
    lv_lo <= 1'b0;
    hv_lo <= 1'b0;
    repeat (5) @(posedge mclk);
    rd(PFM_ADDR_LATCHOFF, 32'h11, PFM_RESP_OKAY);
    wr(PFM_ADDR_LATCHOFF, 32'h11, 4'hF, PFM_RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk_val(32'(nlv + nhv), 32'h0);
    wr(PFM_ADDR_LATCHOFF, 32'h01, 4'hF, PFM_RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk_val(32'(nlv), 32'h1);
    rd(PFM_ADDR_LATCHOFF, 32'h01, PFM_RESP_OKAY);
    wr(PFM_ADDR_LATCHOFF, 32'h10, 4'hF, PFM_RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk_val(32'(nhv), 32'h1);
    rd(PFM_ADDR_LATCHOFF, 32'h00, PFM_RESP_OKAY);
    // response masks gate the primary buck faults
    pfault <= 7'h7F;
    repeat (3) @(posedge mclk);
    chk_val({25'h0, presp}, 32'h68);
    wr(PFM_ADDR_RESP_MASK, 32'h00, 4'hF, PFM_RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk_val({25'h0, presp}, 32'h7F);
    wr(PFM_ADDR_RESP_MASK, 32'hFF, 4'hF, PFM_RESP_OKAY);
    rd(PFM_ADDR_RESP_MASK, 32'h7F, PFM_RESP_OKAY);
    chk_val({25'h0, presp}, 32'h00);
    wr(PFM_ADDR_POLICY, 32'h03, 4'hF, PFM_RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk_val({30'h0, policy}, 32'h3);
    rd(PFM_ADDR_POLICY, 32'h03, PFM_RESP_OKAY);
    results();
  end

endmodule
